// ===== rtl/tid_trigger_debounce.v
// The APB register port and the placing of the registers were left to the implementer.
`include "tid_consts.vh"

// backplane trigger inputs with per-line debounce, routing and apb access
module tid_trigger_debounce #(
  parameter CNT_W = 16,
  parameter SLOW_CYC_P = `TID_SLOW_TB_NS * `TID_PCLK_MHZ / 1000
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [7:0] trig_line_in,
  input wire star_trig_in,
  input wire dstar_a_in,
  input wire dstar_b_in,
  input wire timing_module_present,
  output reg [7:0] internal_trigger_line,
  output reg star_trig,
  output reg dstar_clk,
  output reg dstar_trig,
  output reg dstar_c_out,
  output reg dstar_c_oe,
  output reg ai_ext_src,
  output reg ao_ext_src,
  output reg ctr_ext_src,
  output reg [1:0] ref_clk_sel
);

  localparam NUM_IN = `TID_NUM_IN;

  // filter clock periods in pclk cycles, at least one cycle each
  localparam FAST_RAW = `TID_FAST_TB_NS * `TID_PCLK_MHZ / 1000;
  localparam FAST_CYC = (FAST_RAW < 1) ? 1 : FAST_RAW;
  localparam SLOW_CYC = (SLOW_CYC_P < 1) ? 1 : SLOW_CYC_P;

  // synchroniser stages and filter outputs
  wire [NUM_IN-1:0] raw_in;
  reg [NUM_IN-1:0] sync_a;
  reg [NUM_IN-1:0] sync_b;
  reg present_a;
  reg present_b;
  wire [NUM_IN-1:0] filt_out;

  // software state
  reg [43:0] filt_cfg;
  reg [15:0] custom_n;
  reg custom_slow;
  reg [16:0] route;

  // timebase tick generators
  reg [15:0] slow_cnt;
  wire fast_tick;
  wire slow_tick;

  // bus decode
  wire setup_ph;
  wire wr_en;
  wire addr_ok;
  reg [31:0] next_prdata;

  // route selects
  wire [3:0] sel_ai;
  wire [3:0] sel_ao;
  wire [3:0] sel_ctr;
  wire [3:0] sel_dc;
  wire [15:0] sel_pad;

  // bused lines keep their numbering as internal lines 0..7
  assign raw_in = {dstar_b_in, dstar_a_in, star_trig_in, trig_line_in};

  // two flops on every backplane pin before any logic reads it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= {NUM_IN{1'b0}};
      sync_b <= {NUM_IN{1'b0}};
      present_a <= 1'b0;
      present_b <= 1'b0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      present_a <= timing_module_present;
      present_b <= present_a;
    end
  end

  // slow filter clock, divided from the local clock; a line that moves
  // just after a tick waits up to one slow period for its first sample,
  // which is the jitter that a filter on the slow base adds
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slow_cnt <= 16'h0000;
    else if (slow_tick)
      slow_cnt <= 16'h0000;
    else
      slow_cnt <= slow_cnt + 16'h0001;
  end

  assign slow_tick = (slow_cnt == SLOW_CYC[15:0] - 16'h0001);

  // fast filter clock: 10 ns cannot be reached at 20 MHz, so the fast base
  // collapses to one pclk cycle and no divider flop is kept then; pulse
  // limits of the short and medium settings scale with it
  generate
    if (FAST_CYC > 1)
    begin : g_fast_div
      reg [15:0] fast_cnt;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          fast_cnt <= 16'h0000;
        else if (fast_tick)
          fast_cnt <= 16'h0000;
        else
          fast_cnt <= fast_cnt + 16'h0001;
      end
      assign fast_tick = (fast_cnt == FAST_CYC[15:0] - 16'h0001);
    end
    else
    begin : g_fast_every
      assign fast_tick = 1'b1;
    end
  endgenerate

  // one filter per input, each with its own setting field
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1)
    begin : g_filt
      wire [2:0] set_code;
      reg f_en;
      reg f_tick;
      reg [CNT_W-1:0] f_n;

      assign set_code = filt_cfg[gi*4+2:gi*4];

      // a setting change takes hold at the next edge; a running count
      // carries over into a new setting other than off, which clears it
      // pick the sample count and timebase for this line
      always @*
      begin
        f_en = 1'b1;
        f_tick = fast_tick;
        f_n = `TID_N_SHORT;
        case (set_code)
          `TID_SET_NONE:
          begin
            f_en = 1'b0;
          end
          `TID_SET_SHORT:
          begin
            f_n = `TID_N_SHORT;
          end
          `TID_SET_MEDIUM:
          begin
            f_n = `TID_N_MEDIUM;
          end
          `TID_SET_HIGH:
          begin
            f_n = `TID_N_HIGH;
            f_tick = slow_tick;
          end
          `TID_SET_CUSTOM:
          begin
            f_n = custom_n;
            f_tick = custom_slow ? slow_tick : fast_tick;
          end
          default:
          begin
            f_en = 1'b0;
          end
        endcase
      end

      tid_filter #(
        .CNT_W(CNT_W)
      ) u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .din(sync_b[gi]),
        .enable(f_en),
        .tick(f_tick),
        .n_target(f_n),
        .dout(filt_out[gi])
      );
    end
  endgenerate

  // route select fields
  assign sel_ai = route[`TID_ROUTE_AI_LSB+3:`TID_ROUTE_AI_LSB];
  assign sel_ao = route[`TID_ROUTE_AO_LSB+3:`TID_ROUTE_AO_LSB];
  assign sel_ctr = route[`TID_ROUTE_CTR_LSB+3:`TID_ROUTE_CTR_LSB];
  assign sel_dc = route[`TID_ROUTE_DC_LSB+3:`TID_ROUTE_DC_LSB];

  // star lines A and B read low without a timing module, so no output or route relies on them
  genvar si;
  generate
    for (si = 0; si < 16; si = si + 1)
    begin : g_pad
      if (si == `TID_IDX_DSTAR_A || si == `TID_IDX_DSTAR_B)
      begin : g_gated
        assign sel_pad[si] = filt_out[si] & present_b;
      end
      else if (si < NUM_IN)
      begin : g_open
        assign sel_pad[si] = filt_out[si];
      end
      else
      begin : g_zero
        // selects past the last input read as zero
        assign sel_pad[si] = 1'b0;
      end
    end
  endgenerate

  // registered trigger outputs toward the rest of the card
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_trigger_line <= 8'h00;
      star_trig <= 1'b0;
      dstar_clk <= 1'b0;
      dstar_trig <= 1'b0;
      ai_ext_src <= 1'b0;
      ao_ext_src <= 1'b0;
      ctr_ext_src <= 1'b0;
      dstar_c_out <= 1'b0;
      dstar_c_oe <= 1'b0;
    end
    else
    begin
      internal_trigger_line <= filt_out[7:0];
      // star trigger is only received on its own line; it goes back out only when routed to line C
      star_trig <= filt_out[`TID_IDX_STAR];
      dstar_clk <= sel_pad[`TID_IDX_DSTAR_A];
      dstar_trig <= sel_pad[`TID_IDX_DSTAR_B];
      ai_ext_src <= sel_pad[sel_ai];
      ao_ext_src <= sel_pad[sel_ao];
      ctr_ext_src <= sel_pad[sel_ctr];
      dstar_c_out <= sel_pad[sel_dc];
      dstar_c_oe <= route[`TID_ROUTE_DC_EN_BIT] & present_b;
    end
  end

  // apb: zero wait states; read data latched during setup
  // so a status read shows the state as of the setup edge
  assign setup_ph = psel & ~penable;
  assign pready = psel & penable;
  assign wr_en = psel & penable & pwrite;
  assign addr_ok = (paddr == `TID_REG_FILT_LO) ||
                   (paddr == `TID_REG_FILT_HI) ||
                   (paddr == `TID_REG_CUSTOM) ||
                   (paddr == `TID_REG_ROUTE) ||
                   (paddr == `TID_REG_REFCLK) ||
                   (paddr == `TID_REG_STATUS);

  // read mux; reserved bits read as zero
  always @*
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      `TID_REG_FILT_LO:
        next_prdata = filt_cfg[31:0];
      `TID_REG_FILT_HI:
        next_prdata = {20'h00000, filt_cfg[43:32]};
      `TID_REG_CUSTOM:
        next_prdata = {15'h0000, custom_slow, custom_n};
      `TID_REG_ROUTE:
        next_prdata = {15'h0000, route};
      `TID_REG_REFCLK:
        next_prdata = {30'h00000000, ref_clk_sel};
      `TID_REG_STATUS:
      begin
        next_prdata[NUM_IN-1:0] = filt_out;
        next_prdata[`TID_STAT_RAW_LSB+NUM_IN-1:`TID_STAT_RAW_LSB] = sync_b;
        next_prdata[`TID_STAT_PRESENT_BIT] = present_b;
      end
      default:
        next_prdata = 32'h00000000;
    endcase
  end

  // answer flops, loaded in the setup cycle so they stand in access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= ~addr_ok;
    end
  end

  // register writes take effect on the access edge
  // writes to the read-only status word are dropped without an error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_cfg <= 44'h00000000000;
      custom_n <= `TID_N_CUSTOM_RST;
      custom_slow <= 1'b0;
      route <= 17'h00000;
      ref_clk_sel <= `TID_REF_ONBOARD;
    end
    else if (wr_en)
    begin
      case (paddr)
        `TID_REG_FILT_LO:
          filt_cfg[31:0] <= pwdata & `TID_FILT_LO_MASK;
        `TID_REG_FILT_HI:
          filt_cfg[43:32] <= pwdata[11:0] & `TID_FILT_HI_MASK;
        `TID_REG_CUSTOM:
        begin
          custom_n <= pwdata[15:0];
          custom_slow <= pwdata[`TID_CUSTOM_SLOW_BIT];
        end
        `TID_REG_ROUTE:
          route <= pwdata[16:0];
        `TID_REG_REFCLK:
        begin
          // legacy 10 MHz and unknown codes are dropped silently
          if (pwdata[1:0] == `TID_REF_ONBOARD ||
              pwdata[1:0] == `TID_REF_BP100)
            ref_clk_sel <= pwdata[1:0];
        end
        default:
          route <= route;
      endcase
    end
  end

endmodule

// ===== rtl/tid_consts.vh
`ifndef TID_CONSTS_VH
`define TID_CONSTS_VH

// clock and timebases
`define TID_PCLK_MHZ 20
`define TID_FAST_TB_NS 10
`define TID_SLOW_TB_NS 10000

// input count and index map
`define TID_NUM_IN 11
`define TID_IDX_STAR 8
`define TID_IDX_DSTAR_A 9
`define TID_IDX_DSTAR_B 10

// filter setting codes
`define TID_SET_NONE 3'h0
`define TID_SET_SHORT 3'h1
`define TID_SET_MEDIUM 3'h2
`define TID_SET_HIGH 3'h3
`define TID_SET_CUSTOM 3'h4

// consecutive sample counts
`define TID_N_SHORT 16'h0009
`define TID_N_MEDIUM 16'h0200
`define TID_N_HIGH 16'h0100
`define TID_N_CUSTOM_RST 16'h0009

// register offsets
`define TID_REG_FILT_LO 8'h00
`define TID_REG_FILT_HI 8'h04
`define TID_REG_CUSTOM 8'h08
`define TID_REG_ROUTE 8'h0C
`define TID_REG_REFCLK 8'h10
`define TID_REG_STATUS 8'h14

// field positions and masks
`define TID_FILT_LO_MASK 32'h77777777
`define TID_FILT_HI_MASK 12'h777
`define TID_CUSTOM_SLOW_BIT 16
`define TID_ROUTE_AI_LSB 0
`define TID_ROUTE_AO_LSB 4
`define TID_ROUTE_CTR_LSB 8
`define TID_ROUTE_DC_LSB 12
`define TID_ROUTE_DC_EN_BIT 16
`define TID_STAT_RAW_LSB 16
`define TID_STAT_PRESENT_BIT 31

// reference clock source codes
`define TID_REF_ONBOARD 2'h0
`define TID_REF_BP100 2'h1
`define TID_REF_LEGACY10 2'h2

`endif

// ===== rtl/tid_filter.v
`include "tid_consts.vh"

// one debounce filter: counts consecutive disagreeing samples
module tid_filter #(
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire din,
  input wire enable,
  input wire tick,
  input wire [CNT_W-1:0] n_target,
  output reg dout
);

  reg [CNT_W-1:0] cnt;
  wire [CNT_W-1:0] cnt_inc;
  wire reached;

  assign cnt_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  // n of zero behaves as one, so a filter never locks up
  assign reached = (cnt_inc >= n_target);

  // when enabled, sample only on filter clock ticks and wait for a full run; when off, follow din every cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dout <= 1'b0;
      cnt <= {CNT_W{1'b0}};
    end
    else if (!enable)
    begin
      dout <= din;
      cnt <= {CNT_W{1'b0}};
    end
    else if (tick)
    begin
      if (din == dout)
        cnt <= {CNT_W{1'b0}};
      else if (reached)
      begin
        dout <= din;
        cnt <= {CNT_W{1'b0}};
      end
      else
        cnt <= cnt_inc;
    end
  end

endmodule

// ===== dv/tid_td_asserts.sv
// watches the debounce block from its pins only
module tid_td_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] trig_line_in,
  input wire logic star_trig_in,
  input wire logic dstar_a_in,
  input wire logic dstar_b_in,
  input wire logic timing_module_present,
  input wire logic [7:0] internal_trigger_line,
  input wire logic star_trig,
  input wire logic dstar_clk,
  input wire logic dstar_trig,
  input wire logic dstar_c_oe,
  input wire logic [1:0] ref_clk_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // each checked edge at a trigger output saw its pin four edges earlier
  a_ref_no_legacy: assert property (ref_clk_sel < 2'h2)
    else $error("reference source holds a refused code");
  a_line_rise: assert property (
    $rose(internal_trigger_line[0]) |-> $past(trig_line_in[0], 4))
    else $error("line 0 rose without a high input");
  a_line_fall: assert property (
    $fell(internal_trigger_line[2]) |-> !$past(trig_line_in[2], 4))
    else $error("line 2 fell without a low input");
  a_star_follow: assert property (
    $changed(star_trig) |-> star_trig == $past(star_trig_in, 4))
    else $error("star trigger moved against its input");
  a_clk_source: assert property (
    $rose(dstar_clk) |-> $past(dstar_a_in, 4))
    else $error("star clock rose without line A");
  a_trig_source: assert property (
    $rose(dstar_trig) |-> $past(dstar_b_in, 4))
    else $error("star trigger rose without line B");
  // without a timing module the star lines must go quiet
  a_star_gated: assert property (
    (!timing_module_present)[*6] |=> !dstar_clk && !dstar_trig)
    else $error("star inputs used without timing module");
  a_c_not_driven: assert property (
    (!timing_module_present)[*6] |=> !dstar_c_oe)
    else $error("line C driven without timing module");

  cover property ($rose(internal_trigger_line[0]));
  cover property ($rose(dstar_c_oe));
  cover property ($fell(dstar_clk));
endmodule

bind tid_trigger_debounce tid_td_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .trig_line_in(trig_line_in),
  .star_trig_in(star_trig_in), .dstar_a_in(dstar_a_in),
  .dstar_b_in(dstar_b_in), .timing_module_present(timing_module_present),
  .internal_trigger_line(internal_trigger_line), .star_trig(star_trig),
  .dstar_clk(dstar_clk), .dstar_trig(dstar_trig),
  .dstar_c_oe(dstar_c_oe), .ref_clk_sel(ref_clk_sel)
);

// ===== dv/tid_bp_model.sv
// backplane pins: 0..7 bused, 8 star, 9 A, 10 B, 11 module present
module tid_bp_model (
  input wire logic pclk,
  output logic [11:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // all pins quiet and no timing module until told
  initial
  begin
    pins = 12'h000;
  end

  // slot clocks: 100 MHz reference and 10 MHz sync at 10% duty
  logic ref100;
  logic sync10;
  initial
  begin
    ref100 = 1'b0;
    forever #5 ref100 = ~ref100;
  end
  initial
  begin
    sync10 = 1'b0;
    forever
    begin
      #90 sync10 = 1'b1;
      #10 sync10 = 1'b0;
    end
  end

  // pins change only just after an edge, like real slot logic
  task automatic set_mask(input logic [11:0] m, input logic lvl);
    @(posedge pclk);
    pins <= lvl ? (pins | m) : (pins & ~m);
  endtask

  // level held for n whole cycles, then back
  task automatic pulse(input int i, input int n, input logic lvl);
    @(posedge pclk);
    pins[i] <= lvl;
    repeat (n) @(posedge pclk);
    pins[i] <= !lvl;
  endtask
endmodule

// ===== dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] q;
  logic err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, star_trig, dstar_clk, dstar_trig;
  wire logic c_out, c_oe, ai, ao, ctr;
  wire logic [1:0] ref_sel;
  wire logic [7:0] itl;
  wire logic [11:0] pins;
  wire logic [10:0] outs;
  int n_mismatch;
  int samples_checked;
  int cycles;

  assign outs = {dstar_trig, dstar_clk, star_trig, itl};

  // slow timebase shortened to 4 cycles
  tid_trigger_debounce #(.SLOW_CYC_P(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_line_in(pins[7:0]),
    .star_trig_in(pins[8]), .dstar_a_in(pins[9]), .dstar_b_in(pins[10]),
    .timing_module_present(pins[11]), .internal_trigger_line(itl),
    .star_trig(star_trig), .dstar_clk(dstar_clk), .dstar_trig(dstar_trig),
    .dstar_c_out(c_out), .dstar_c_oe(c_oe), .ai_ext_src(ai),
    .ao_ext_src(ao), .ctr_ext_src(ctr), .ref_clk_sel(ref_sel)
  );
  tid_bp_model BP (.pclk(pclk), .pins(pins));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // hang guard, well above the longest expected run
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // one apb transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a next call never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // pulse one pin and see whether the filtered copy ever shows it
  task automatic pulse_chk(input int i, input int n, input logic lvl,
                           input logic exp);
    logic seen;
    seen = 1'b0;
    fork
      BP.pulse(i, n, lvl);
      repeat (n + 12) @(negedge pclk) seen |= (outs[i] === lvl);
    join
    chk(seen === exp, "pulse filtering wrong");
    repeat (n + 12) @(posedge pclk);
  endtask

  task automatic t_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk(q === 32'h0, "filters not off");
    apb(1'b0, 8'h08, 32'h0);
    chk(q[15:0] === 16'h0009, "custom count");
    apb(1'b0, 8'h20, 32'h0);
    chk(err === 1'b1, "unmapped read accepted");
    pulse_chk(3, 2, 1'b1, 1'b1);
  endtask

  task automatic t_short;
    wr(8'h00, 32'h1);
    pulse_chk(0, 8, 1'b1, 1'b0);
    pulse_chk(0, 9, 1'b1, 1'b1);
    pulse_chk(1, 2, 1'b1, 1'b1);
    wr(8'h04, 32'h1);
    pulse_chk(8, 8, 1'b1, 1'b0);
    pulse_chk(8, 9, 1'b1, 1'b1);
    wr(8'h04, 32'h0);
  endtask

  // ten high samples split by one low one must not pass
  task automatic t_restart;
    logic seen;
    seen = 1'b0;
    fork
      begin
        BP.pulse(0, 5, 1'b1);
        BP.pulse(0, 5, 1'b1);
      end
      repeat (26) @(negedge pclk) seen |= (outs[0] === 1'b1);
    join
    chk(seen === 1'b0, "count kept over a gap");
    @(posedge pclk);
  endtask

  task automatic t_medium;
    wr(8'h00, 32'h2);
    pulse_chk(0, 511, 1'b1, 1'b0);
    pulse_chk(0, 512, 1'b1, 1'b1);
  endtask

  // tick phase may cost one tick, hence the margins
  task automatic t_high;
    wr(8'h00, 32'h3);
    pulse_chk(0, 1010, 1'b1, 1'b0);
    pulse_chk(0, 1040, 1'b1, 1'b1);
  endtask

  task automatic t_custom;
    wr(8'h08, 32'h14);
    wr(8'h00, 32'h4);
    pulse_chk(0, 19, 1'b1, 1'b0);
    pulse_chk(0, 20, 1'b1, 1'b1);
    wr(8'h08, 32'h00010005);
    pulse_chk(0, 15, 1'b1, 1'b0);
    pulse_chk(0, 24, 1'b1, 1'b1);
    wr(8'h00, 32'h7);
    pulse_chk(0, 2, 1'b1, 1'b1);
    wr(8'h00, 32'h0);
  endtask

  task automatic t_fall;
    wr(8'h00, 32'h100);
    BP.set_mask(12'h004, 1'b1);
    repeat (20) @(posedge pclk);
    chk(outs[2] === 1'b1, "line 2 not high");
    pulse_chk(2, 8, 1'b0, 1'b0);
    pulse_chk(2, 9, 1'b0, 1'b1);
    BP.set_mask(12'h004, 1'b0);
    repeat (20) @(posedge pclk);
  endtask

  // star to ai, A to ao, B to counter, line 5 out on C
  task automatic t_route;
    wr(8'h0C, 32'h00015A98);
    BP.set_mask(12'h720, 1'b1);
    repeat (10) @(posedge pclk);
    chk({ai, ao, ctr, c_out, c_oe, dstar_clk, dstar_trig, star_trig} ===
        8'hFF, "routing wrong");
    apb(1'b0, 8'h14, 32'h0);
    chk(q === 32'h87200720, "status wrong");
    BP.set_mask(12'h800, 1'b0);
    repeat (10) @(posedge pclk);
    chk({dstar_clk, dstar_trig, c_oe} === 3'h0, "star used");
    BP.set_mask(12'h720, 1'b0);
    BP.set_mask(12'h800, 1'b1);
  endtask

  task automatic t_ref;
    wr(8'h10, 32'h1);
    wr(8'h10, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk(q[1:0] === 2'h1 && ref_sel === 2'h1, "legacy taken");
    wr(8'h10, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk(q[1:0] === 2'h1, "code 3 taken");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk(q === 32'h0 && ref_sel === 2'h0, "source not reset");
    apb(1'b0, 8'h00, 32'h0);
    chk(q === 32'h0, "filters on after reset");
  endtask

  // slot clocks from the backplane model
  task automatic t_clocks;
    time t0;
    @(posedge BP.sync10);
    t0 = $time;
    @(negedge BP.sync10);
    chk($time - t0 == 10, "sync clock duty");
    @(posedge BP.ref100);
    t0 = $time;
    repeat (10) @(posedge BP.ref100);
    chk($time - t0 == 100, "reference clock period");
    @(posedge pclk);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    BP.set_mask(12'h800, 1'b1);
    t_reset();
    t_short();
    t_restart();
    t_medium();
    t_high();
    t_custom();
    t_fall();
    t_route();
    t_ref();
    t_clocks();
    finish_test();
  end
endmodule
